// ---- src/wst_top.sv ----
// Watchdog and oscillation stabilization timer with its register port
//
// Overview of operation
// - Counter clock is oscillator divided by 4096, 1024 or 128 via prescaler.
// - Eight-bit up-counter readable at DDH, writes to it are ignored.
// - Reset loads control with 00H: watchdog on, divide by 4096.
// - Watchdog reset is off only while control bits 7..4 hold 1010B.
// - Writing one to control bit 1 clears the counter.
// - Writing one to control bit 0 clears the prescaler.
// - Counter overflow out of bit 7 requests system reset when enabled.
// - After reset count at /4096; after stop wake at preset clock.
// - Counter bit 4 set ends stabilization and releases the CPU clock.
// - Stop release stabilization lasts 16 prescaled ticks; setting 11 invalid.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module wst_top
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire wst_pkg::wst_bus_s bus_in,
  input wire logic stop_req_in,
  input wire logic wake_in,
  output logic [7:0] rdata_out,
  output logic wdt_reset_out,
  output logic cpu_clk_en_out
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [7:2] ctrl;
    logic [11:0] presc;
    logic [7:0] count;
    wst_pkg::wst_mode_e mode;
    logic [7:0] rdata;
    logic wdt_rst;
    logic clk_en;
    logic [1:0] wake_sync;
  } wst_state_s;

  wst_state_s st_reg;
  wst_state_s st_next;
  logic tick;
  logic ctrl_wr;
  logic wdt_enabled;
  logic [11:0] div_mask;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    st_next = st_reg;
    ctrl_wr = bus_in.wr && (bus_in.addr == wst_pkg::WST_ADDR_CONTROL);
    wdt_enabled = (st_reg.ctrl[7:4] != wst_pkg::WST_SIG_DISABLE);
    // Divider tap per selection; the invalid code yields no ticks at all
    unique case (wst_pkg::wst_sel_e'(st_reg.ctrl[3:2]))
      wst_pkg::WST_SEL_DIV4096: div_mask = wst_pkg::WST_MASK_4096;
      wst_pkg::WST_SEL_DIV1024: div_mask = wst_pkg::WST_MASK_1024;
      wst_pkg::WST_SEL_DIV128: div_mask = wst_pkg::WST_MASK_128;
      wst_pkg::WST_SEL_INVALID: div_mask = wst_pkg::WST_MASK_4096;
    endcase
    // Oscillator stands still in stop mode, so the prescaler freezes there
    tick = (st_reg.mode != wst_pkg::WST_MODE_STOPPED)
      && (st_reg.ctrl[3:2] != wst_pkg::WST_SEL_INVALID)
      && ((st_reg.presc & div_mask) == div_mask);

    // Wake pin is asynchronous: two flip-flops before use
    st_next.wake_sync = {st_reg.wake_sync[0], wake_in};
    st_next.wdt_rst = 1'b0;
    st_next.rdata = 8'h00;

    if (st_reg.mode != wst_pkg::WST_MODE_STOPPED)
    begin
      st_next.presc = st_reg.presc + 12'h001;
    end
    if (tick)
    begin
      st_next.count = st_reg.count + 8'h01;
      if (st_reg.count == 8'hff && wdt_enabled)
      begin
        st_next.wdt_rst = 1'b1;
      end
    end

    // Control write; clear bits act once and are not stored
    if (ctrl_wr)
    begin
      st_next.ctrl = bus_in.wdata[7:2];
      if (bus_in.wdata[wst_pkg::WST_CLR_COUNT_BIT])
      begin
        st_next.count = 8'h00;
        st_next.wdt_rst = 1'b0;
      end
      if (bus_in.wdata[wst_pkg::WST_CLR_PRESC_BIT])
      begin
        st_next.presc = 12'h000;
      end
    end

    // Register reads; the count register ignores writes
    if (bus_in.rd)
    begin
      if (bus_in.addr == wst_pkg::WST_ADDR_CONTROL)
      begin
        st_next.rdata = {st_reg.ctrl, 2'b00};
      end
      else if (bus_in.addr == wst_pkg::WST_ADDR_COUNT)
      begin
        st_next.rdata = st_reg.count;
      end
    end

    // Mode sequencing
    unique case (st_reg.mode)
      wst_pkg::WST_MODE_STABILIZE:
      begin
        st_next.clk_en = 1'b0;
        if (st_reg.count[wst_pkg::WST_STAB_BIT])
        begin
          st_next.mode = wst_pkg::WST_MODE_RUN;
          st_next.clk_en = 1'b1;
        end
      end
      wst_pkg::WST_MODE_RUN:
      begin
        st_next.clk_en = 1'b1;
        if (stop_req_in)
        begin
          st_next.mode = wst_pkg::WST_MODE_STOPPED;
          st_next.clk_en = 1'b0;
        end
      end
      wst_pkg::WST_MODE_STOPPED:
      begin
        st_next.clk_en = 1'b0;
        // Wake keeps the preset divider; fresh count gives 16 ticks to bit 4
        if (st_reg.wake_sync[1])
        begin
          st_next.mode = wst_pkg::WST_MODE_STABILIZE;
          st_next.count = 8'h00;
          st_next.presc = 12'h000;
        end
      end
    endcase
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      st_reg.ctrl <= wst_pkg::WST_CONTROL_RESET[7:2];
      st_reg.presc <= 12'h000;
      st_reg.count <= wst_pkg::WST_COUNT_RESET;
      st_reg.mode <= wst_pkg::WST_MODE_STABILIZE;
      st_reg.rdata <= 8'h00;
      st_reg.wdt_rst <= 1'b0;
      st_reg.clk_en <= 1'b0;
      st_reg.wake_sync <= 2'b00;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rdata_out = st_reg.rdata;
  assign wdt_reset_out = st_reg.wdt_rst;
  assign cpu_clk_en_out = st_reg.clk_en;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);

  // Count only steps by one, clears, or holds
  AST_COUNT_STEP: assert property (
    st_reg.count != $past(st_reg.count) |->
      (st_reg.count == $past(st_reg.count) + 8'h01) || (st_reg.count == 8'h00))
    else $error("Count changed other than by one step or clear");

  AST_RESET_VALUES: assert property (
    $past(reset_in) |-> (st_reg.ctrl == 6'h00) && (st_reg.count == 8'h00)
      && !cpu_clk_en_out)
    else $error("Reset values wrong after reset release");

  // Pulse loops back as system reset; the default disable would hide it
  AST_WDT_GATED: assert property (
    @(posedge mclk_in) disable iff (1'b0)
    wdt_reset_out |-> $past(st_reg.ctrl[7:4]) != wst_pkg::WST_SIG_DISABLE)
    else $error("Watchdog reset fired while disabled");

  AST_CLEAR_COUNT: assert property (
    ctrl_wr && bus_in.wdata[1] && st_reg.mode != wst_pkg::WST_MODE_STOPPED
      |=> st_reg.count == 8'h00)
    else $error("Count not cleared by control write");

  AST_CLEAR_PRESC: assert property (
    ctrl_wr && bus_in.wdata[0] |=> st_reg.presc == 12'h000)
    else $error("Prescaler not cleared by control write");

  AST_OVERFLOW_RESET: assert property (
    @(posedge mclk_in) disable iff (1'b0)
    !reset_in && tick && st_reg.count == 8'hff && wdt_enabled
      && !(ctrl_wr && bus_in.wdata[1]) |=> wdt_reset_out ##1 !wdt_reset_out)
    else $error("Overflow did not give one reset pulse");

  AST_TICK_RATE: assert property (
    $past(st_reg.ctrl[3:2]) == 2'h0 && st_reg.count != 8'h00
      && st_reg.count == $past(st_reg.count) + 8'h01 |-> $past(st_reg.presc) == 12'hfff)
    else $error("Count stepped at wrong prescaler phase for divide by 4096");

  AST_INVALID_SEL: assert property (
    $past(st_reg.ctrl[3:2]) == 2'h3 && $past(st_reg.mode) != wst_pkg::WST_MODE_STOPPED
      && !$past(ctrl_wr) && !$past(reset_in) |-> $stable(st_reg.count))
    else $error("Count moved with invalid clock selection");

  AST_STAB_RELEASE: assert property (
    st_reg.mode == wst_pkg::WST_MODE_STABILIZE && st_reg.count[4]
      |=> cpu_clk_en_out && st_reg.mode == wst_pkg::WST_MODE_RUN)
    else $error("CPU clock not released when count bit 4 set");

  AST_WAKE_RESTART: assert property (
    st_reg.mode == wst_pkg::WST_MODE_STOPPED && st_reg.wake_sync[1]
      |=> st_reg.count == 8'h00 && !cpu_clk_en_out
        && st_reg.mode == wst_pkg::WST_MODE_STABILIZE)
    else $error("Wake did not restart stabilization");

  AST_READ_LATENCY: assert property (
    bus_in.rd && bus_in.addr == wst_pkg::WST_ADDR_COUNT |=> rdata_out == $past(st_reg.count))
    else $error("Count read data wrong");

  AST_TICK_RATE_1024: assert property (
    $past(st_reg.ctrl[3:2]) == 2'h1 && st_reg.count != 8'h00
      && st_reg.count == $past(st_reg.count) + 8'h01 |-> $past(st_reg.presc[9:0]) == 10'h3ff)
    else $error("Count stepped at wrong prescaler phase for divide by 1024");

  AST_TICK_RATE_128: assert property (
    $past(st_reg.ctrl[3:2]) == 2'h2 && st_reg.count != 8'h00
      && st_reg.count == $past(st_reg.count) + 8'h01 |-> $past(st_reg.presc[6:0]) == 7'h7f)
    else $error("Count stepped at wrong prescaler phase for divide by 128");

  AST_WDT_PULSE: assert property (
    @(posedge mclk_in) disable iff (1'b0)
    wdt_reset_out |=> !wdt_reset_out)
    else $error("Watchdog reset longer than one cycle");

  AST_RDATA_IDLE: assert property (
    !$past(bus_in.rd) |-> rdata_out == 8'h00)
    else $error("Read data not zero outside the read answer cycle");

  AST_CTRL_READ: assert property (
    bus_in.rd && bus_in.addr == wst_pkg::WST_ADDR_CONTROL
      |=> rdata_out == {$past(st_reg.ctrl), 2'b00})
    else $error("Control read data wrong");

  AST_UNMAPPED_READ: assert property (
    bus_in.rd && bus_in.addr != wst_pkg::WST_ADDR_CONTROL
      && bus_in.addr != wst_pkg::WST_ADDR_COUNT |=> rdata_out == 8'h00)
    else $error("Unmapped read returned nonzero data");

  AST_CTRL_WRITE: assert property (
    ctrl_wr |=> st_reg.ctrl == $past(bus_in.wdata[7:2]))
    else $error("Control write not stored");

  AST_STOP_FREEZE: assert property (
    st_reg.mode == wst_pkg::WST_MODE_STOPPED && !st_reg.wake_sync[1] && !ctrl_wr
      |=> $stable(st_reg.count) && $stable(st_reg.presc))
    else $error("Counter or prescaler moved in stop mode");

  AST_STOP_ENTRY: assert property (
    st_reg.mode == wst_pkg::WST_MODE_RUN && stop_req_in
      |=> st_reg.mode == wst_pkg::WST_MODE_STOPPED && !cpu_clk_en_out)
    else $error("Stop request did not gate the CPU clock");

  AST_RUN_HOLD: assert property (
    st_reg.mode == wst_pkg::WST_MODE_RUN && !stop_req_in
      |=> st_reg.mode == wst_pkg::WST_MODE_RUN && cpu_clk_en_out)
    else $error("CPU clock dropped while running");

  AST_STAB_GATED: assert property (
    st_reg.mode == wst_pkg::WST_MODE_STABILIZE |-> !cpu_clk_en_out)
    else $error("CPU clock released during stabilization");

  AST_RESET_STATE: assert property (
    $past(reset_in) |-> st_reg.mode == wst_pkg::WST_MODE_STABILIZE
      && st_reg.presc == 12'h000 && !wdt_reset_out && rdata_out == 8'h00)
    else $error("Mode, prescaler or outputs wrong after reset release");

  COV_OVERFLOW: cover property (
    @(posedge mclk_in) disable iff (1'b0) wdt_reset_out);
  COV_STAB_DONE: cover property (
    st_reg.mode == wst_pkg::WST_MODE_STABILIZE ##1 st_reg.mode == wst_pkg::WST_MODE_RUN);
  COV_STOP_WAKE: cover property (
    st_reg.mode == wst_pkg::WST_MODE_STOPPED ##1 st_reg.mode == wst_pkg::WST_MODE_STABILIZE);
  COV_DISABLE: cover property (ctrl_wr && bus_in.wdata[7:4] == 4'ha);

endmodule // wst_top

`default_nettype wire

// ---- shared/wst_pkg.sv ----
// Package: register map, field layout and timing constants of the watchdog timer
package wst_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned WST_CLK_PERIOD_PS = 25000;
  localparam int unsigned WST_PRESC_W = 12;
  localparam int unsigned WST_CNT_W = 8;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] WST_ADDR_CONTROL = 8'hdc;
  localparam logic [7:0] WST_ADDR_COUNT = 8'hdd;
  localparam logic [7:0] WST_CONTROL_RESET = 8'h00;
  localparam logic [7:0] WST_COUNT_RESET = 8'h00;

  // Control fields
  localparam int unsigned WST_SIG_MSB = 7;
  localparam int unsigned WST_SIG_LSB = 4;
  localparam int unsigned WST_SEL_MSB = 3;
  localparam int unsigned WST_SEL_LSB = 2;
  localparam int unsigned WST_CLR_COUNT_BIT = 1;
  localparam int unsigned WST_CLR_PRESC_BIT = 0;
  localparam logic [3:0] WST_SIG_DISABLE = 4'ha;
  localparam int unsigned WST_STAB_BIT = 4;

  // ==========================================================================
  // Clock selection
  // ==========================================================================
  typedef enum logic [1:0] {
    WST_SEL_DIV4096 = 2'h0,
    WST_SEL_DIV1024 = 2'h1,
    WST_SEL_DIV128 = 2'h2,
    WST_SEL_INVALID = 2'h3
  } wst_sel_e;

  localparam logic [11:0] WST_MASK_4096 = 12'hfff;
  localparam logic [11:0] WST_MASK_1024 = 12'h3ff;
  localparam logic [11:0] WST_MASK_128 = 12'h07f;

  typedef enum logic [1:0] {
    WST_MODE_STABILIZE,
    WST_MODE_RUN,
    WST_MODE_STOPPED
  } wst_mode_e;

  // Register access port bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wst_bus_s;

endpackage : wst_pkg

// ---- tb/wst_top_test.sv ----
// Self-checking bench for the watchdog and stabilization timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module wst_top_test;
  logic mclk_in = 1'b0;
  logic rst_reg = 1'b1;
  logic stop_req = 1'b0;
  logic wake = 1'b0;
  wst_pkg::wst_bus_s bus = '0;
  logic [7:0] rdata;
  logic wdt_rst;
  logic clk_en;
  logic sys_reset;
  int errors = 0;
  int compares = 0;
  logic [7:0] rv;
  logic [7:0] c1;
  logic [7:0] w;
  logic [3:0] sig;
  logic [1:0] sel;
  int n;

  // Watchdog pulse loops back as a system reset
  assign sys_reset = rst_reg | wdt_rst;

  wst_top wst_top_inst (
    .mclk_in(mclk_in),
    .reset_in(sys_reset),
    .bus_in(bus),
    .stop_req_in(stop_req),
    .wake_in(wake),
    .rdata_out(rdata),
    .wdt_reset_out(wdt_rst),
    .cpu_clk_en_out(clk_en)
  );

  initial
  begin
    forever #12.5 mclk_in = ~mclk_in;
  end

  // ==========================================================================
  // Bus tasks and expectations
  // ==========================================================================
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_in);
  endtask

  task automatic wr_ctrl(input logic [7:0] d, input logic [7:0] a = wst_pkg::WST_ADDR_CONTROL);
    @(posedge mclk_in);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge mclk_in);
    bus.wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk_in);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rd_cnt(output logic [7:0] d);
    rd_reg(wst_pkg::WST_ADDR_COUNT, d);
  endtask

  function automatic logic [7:0] ctrl_rb(input logic [7:0] v);
    return {v[7:2], 2'b00};
  endfunction

  function automatic int tick_len(input logic [1:0] s);
    return (s == 2'h0) ? 4096 : (s == 2'h1) ? 1024 : 128;
  endfunction

  task automatic wrap_up;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial
  begin
    void'($urandom(94));
    cyc(6);
    rst_reg <= 1'b0;
    rd_reg(wst_pkg::WST_ADDR_CONTROL, rv);
    `CHK(rv, 8'h00)
    cyc(6144);
    rd_cnt(rv);
    `CHK(rv, 8'h01)
    `CHK(clk_en, 1'b0)
    // Faster select so the release comes just after 2048 cycles
    wr_ctrl(8'h0b);
    cyc(1984);
    #1 `CHK(clk_en, 1'b0)
    cyc(128);
    #1 `CHK(clk_en, 1'b1)
    repeat (8)
    begin
      w = 8'($urandom);
      wr_ctrl(w);
      rd_reg(wst_pkg::WST_ADDR_CONTROL, rv);
      `CHK(rv, ctrl_rb(w))
    end
    wr_ctrl(8'hab);
    wr_ctrl(8'hff, wst_pkg::WST_ADDR_COUNT);
    rd_cnt(rv);
    `CHK(rv, 8'h00)
    @(posedge mclk_in);
    #1 `CHK(rdata, 8'h00)
    rd_reg(8'h42, rv);
    `CHK(rv, 8'h00)
    for (int s = 0; s < 3; s++)
    begin
      sel = 2'(s);
      wr_ctrl({4'ha, sel, 2'b11});
      cyc(tick_len(sel) * 2 + tick_len(sel) / 2);
      rd_cnt(rv);
      `CHK(rv, 8'h02)
    end
    wr_ctrl(8'haf);
    cyc(300);
    rd_cnt(rv);
    `CHK(rv, 8'h00)
    wr_ctrl(8'hab);
    cyc(640);
    rd_cnt(rv);
    `CHK(rv, 8'h05)
    wr_ctrl(8'haa);
    rd_cnt(rv);
    `CHK(rv, 8'h00)
    // Stop freezes the count, wake restarts stabilization at the preset rate
    @(posedge mclk_in);
    stop_req <= 1'b1;
    @(posedge mclk_in);
    stop_req <= 1'b0;
    cyc(2);
    #1 `CHK(clk_en, 1'b0)
    rd_cnt(c1);
    cyc(500);
    rd_cnt(rv);
    `CHK(rv, c1)
    @(posedge mclk_in);
    wake <= 1'b1;
    cyc(4);
    wake <= 1'b0;
    cyc(1980);
    #1 `CHK(clk_en, 1'b0)
    cyc(128);
    #1 `CHK(clk_en, 1'b1)
    wr_ctrl(8'hab);
    n = 0;
    repeat (32832)
    begin
      @(posedge mclk_in);
      if (wdt_rst === 1'b1)
        n++;
    end
    `CHK(n, 0)
    rd_cnt(rv);
    `CHK(rv, 8'h00)
    sig = 4'($urandom);
    if (sig == 4'ha)
      sig = 4'h5;
    wr_ctrl({sig, 4'hb});
    // A timely clear pushes the overflow a full period past the clear
    cyc(4096);
    #1 `CHK(wdt_rst, 1'b0)
    wr_ctrl({sig, 4'ha});
    n = 0;
    while (wdt_rst !== 1'b1 && n < 33000)
    begin
      @(posedge mclk_in);
      #1 n++;
    end
    if (n >= 33000)
      errors++;
    else
    begin
      `CHK(n >= 32760 && n <= 32780, 1'b1)
      cyc(2);
      rd_reg(wst_pkg::WST_ADDR_CONTROL, rv);
      `CHK(rv, 8'h00)
      `CHK(clk_en, 1'b0)
    end
    wrap_up();
  end
endmodule // wst_top_test
`default_nettype wire
